/* verilog/spr_device.sv */
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module spr_device (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [spr_pkg::ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_global_irq_en,
    input wire logic i_tx_done_irq_ack,
    output logic o_rx_done_irq,
    output logic o_tx_done_irq,
    output logic o_tx_empty_irq,
    spr_link_if.dev link
);
    typedef struct packed {
        logic [7:0] cb;
        logic [7:0] cc;
        logic dbl;
        logic mpcm;
        logic [spr_pkg::BAUD_W-1:0] baud;
        logic [8:0] tx_holding_buffer;
        logic tx_holding_full;
        logic txc;
        logic own;
        spr_pkg::spr_tx_e tx_st;
        logic [8:0] tx_sh;
        logic [3:0] tx_bit;
        logic [3:0] tx_os;
        logic tx_par;
        logic tx_line;
        spr_pkg::spr_rx_e rx_st;
        logic [8:0] rx_sh;
        logic [3:0] rx_bit;
        logic [3:0] rx_os;
        logic rx_pb;
        logic [1:0][spr_pkg::ENT_W-1:0] fifo;
        logic [1:0] fcnt;
        logic [spr_pkg::ENT_W-1:0] hold;
        logic hold_v;
        logic dor;
        logic [7:0] rdata;
    } spr_dev_s;
    spr_dev_s r, n;

    logic tick;
    logic baud_load;
    logic [3:0] os_last;
    logic [3:0] nb;
    logic [8:0] mask;
    logic is_async;
    logic rxc;
    logic rx_in;
    logic [8:0] rx_word;
    logic rx_ptype;
    logic [spr_pkg::ENT_W-1:0] rx_ent;

    assign baud_load = i_wr && (i_addr == spr_pkg::ADDR_BAUD_LO);

    spr_baud_gen #(.BAUD_W(spr_pkg::BAUD_W)) spr_baud_gen_inst (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_divisor(n.baud),
        .i_load(baud_load),
        .o_tick(tick)
    );

    assign os_last = r.dbl ? 4'(spr_pkg::OS_DBL - 5'h01) : 4'(spr_pkg::OS_NORM - 5'h01); // [R12]
    assign nb = spr_pkg::spr_char_bits({r.cb[spr_pkg::B_CSZ2], r.cc[spr_pkg::C_CSZ1:spr_pkg::C_CSZ0]}); // [R20]
    assign mask = ~(9'h1FF << nb); // [R2]
    // sync and spi modes need a clock pin this link lacks, so they idle the engines
    assign is_async = r.cc[spr_pkg::C_MODE_HI:spr_pkg::C_MODE_LO] == spr_pkg::MODE_ASYNC; // [R19]
    assign rxc = r.fcnt != 2'h0; // [R6]
    assign rx_in = link.line_r2d;
    assign rx_word = 9'(r.rx_sh >> (4'h9 - nb)) & mask; // [R2]
    assign rx_ptype = (nb == 4'h9) ? rx_word[8] : rx_in; // [R13]
    assign rx_ent = {r.cc[spr_pkg::C_UPM1] & (r.rx_pb != ((^rx_word) ^ r.cc[spr_pkg::C_UPM0])), ~rx_in, rx_word}; // [R9] [R11] [R21]

    always_comb begin
        n = r;
        n.rdata = 8'h00;
        if (i_wr) begin
            case (i_addr)
                spr_pkg::ADDR_DATA: begin
                    if (!r.tx_holding_full) begin // [R3]
                        n.tx_holding_buffer = {r.cb[spr_pkg::B_TXB8], i_wdata} & mask; // [R1] [R2]
                        n.tx_holding_full = 1'b1;
                    end
                end
                spr_pkg::ADDR_STAT_A: begin
                    n.dbl = i_wdata[spr_pkg::A_DBL];
                    n.mpcm = i_wdata[spr_pkg::A_MPCM];
                    if (i_wdata[spr_pkg::A_TXC]) begin
                        n.txc = 1'b0; // [R7]
                    end
                end
                spr_pkg::ADDR_CTRL_B: n.cb = i_wdata & spr_pkg::CTRL_B_WMASK;
                spr_pkg::ADDR_CTRL_C: n.cc = i_wdata;
                spr_pkg::ADDR_BAUD_LO: n.baud[7:0] = i_wdata; // [R23]
                spr_pkg::ADDR_BAUD_HI: n.baud[11:8] = i_wdata[3:0];
                default: ;
            endcase
        end
        if (i_tx_done_irq_ack) begin
            n.txc = 1'b0; // [R7]
        end
        if (i_rd) begin
            case (i_addr)
                spr_pkg::ADDR_DATA: n.rdata = r.fifo[0][7:0]; // [R1]
                spr_pkg::ADDR_STAT_A: n.rdata = {rxc, r.txc, ~r.tx_holding_full, rxc & r.fifo[0][spr_pkg::ENT_FE],
                                                 r.dor, rxc & r.fifo[0][spr_pkg::ENT_PE], r.dbl, r.mpcm}; // [R8] [R9]
                spr_pkg::ADDR_CTRL_B: n.rdata = r.cb | {6'h00, r.fifo[0][8], 1'b0};
                spr_pkg::ADDR_CTRL_C: n.rdata = r.cc;
                spr_pkg::ADDR_BAUD_LO: n.rdata = r.baud[7:0];
                spr_pkg::ADDR_BAUD_HI: n.rdata = {4'h0, r.baud[11:8]};
                default: n.rdata = 8'h00;
            endcase
            if (i_addr == spr_pkg::ADDR_DATA && rxc) begin // [R5] [R24]
                n.fifo[0] = r.fifo[1];
                n.dor = 1'b0; // [R10]
                if (r.hold_v) begin
                    n.fifo[1] = r.hold;
                    n.hold_v = 1'b0;
                end else begin
                    n.fcnt = r.fcnt - 2'h1;
                end
            end
        end

        // pin stays owned until shifter and buffer drain
        n.own = r.cb[spr_pkg::B_TXEN] | (r.own & ((r.tx_st != spr_pkg::TX_IDLE) | r.tx_holding_full)); // [R16]
        if (r.tx_st == spr_pkg::TX_IDLE) begin
            if (r.own && r.tx_holding_full && is_async) begin // [R4]
                n.tx_sh = r.tx_holding_buffer;
                n.tx_holding_full = 1'b0;
                n.tx_par = (^r.tx_holding_buffer) ^ r.cc[spr_pkg::C_UPM0]; // [R21]
                n.tx_st = spr_pkg::TX_START;
                n.tx_os = 4'h0;
                n.tx_bit = 4'h0;
            end
        end else if (tick) begin
            if (r.tx_os != os_last) begin
                n.tx_os = r.tx_os + 4'h1;
            end else begin
                n.tx_os = 4'h0;
                case (r.tx_st)
                    spr_pkg::TX_START: n.tx_st = spr_pkg::TX_DATA;
                    spr_pkg::TX_DATA: begin
                        n.tx_sh = {1'b0, r.tx_sh[8:1]};
                        n.tx_bit = r.tx_bit + 4'h1;
                        if (r.tx_bit == 4'(nb - 4'h1)) begin
                            n.tx_st = r.cc[spr_pkg::C_UPM1] ? spr_pkg::TX_PAR : spr_pkg::TX_STOP1;
                        end
                    end
                    spr_pkg::TX_PAR: n.tx_st = spr_pkg::TX_STOP1;
                    spr_pkg::TX_STOP1: n.tx_st = r.cc[spr_pkg::C_USBS] ? spr_pkg::TX_STOP2 : spr_pkg::TX_IDLE; // [R22]
                    default: n.tx_st = spr_pkg::TX_IDLE;
                endcase
                if (n.tx_st == spr_pkg::TX_IDLE && !r.tx_holding_full) begin
                    n.txc = 1'b1; // [R7]
                end
            end
        end
        case (n.tx_st)
            spr_pkg::TX_START: n.tx_line = 1'b0;
            spr_pkg::TX_DATA: n.tx_line = n.tx_sh[0];
            spr_pkg::TX_PAR: n.tx_line = n.tx_par;
            default: n.tx_line = 1'b1;
        endcase

        if (!r.cb[spr_pkg::B_RXEN] || !is_async) begin
            n.rx_st = spr_pkg::RX_IDLE;
            if (!r.cb[spr_pkg::B_RXEN]) begin // [R6] [R15]
                n.fcnt = 2'h0;
                n.hold_v = 1'b0;
                n.dor = 1'b0;
            end
        end else if (tick) begin
            n.rx_os = r.rx_os + 4'h1;
            case (r.rx_st)
                spr_pkg::RX_IDLE: begin
                    if (!rx_in) begin
                        n.rx_st = spr_pkg::RX_START;
                        n.rx_os = 4'h0;
                        if (n.fcnt == 2'h2 && n.hold_v) begin
                            n.dor = 1'b1; // [R10]
                        end
                    end
                end
                spr_pkg::RX_START: begin
                    if (r.rx_os == (os_last >> 1)) begin
                        n.rx_os = 4'h0;
                        n.rx_bit = 4'h0;
                        n.rx_st = rx_in ? spr_pkg::RX_IDLE : spr_pkg::RX_DATA;
                    end
                end
                default: begin
                    if (r.rx_os == os_last) begin
                        n.rx_os = 4'h0;
                        case (r.rx_st)
                            spr_pkg::RX_DATA: begin
                                n.rx_sh = {rx_in, r.rx_sh[8:1]};
                                n.rx_bit = r.rx_bit + 4'h1;
                                if (r.rx_bit == 4'(nb - 4'h1)) begin
                                    n.rx_st = r.cc[spr_pkg::C_UPM1] ? spr_pkg::RX_PAR : spr_pkg::RX_STOP;
                                end
                            end
                            spr_pkg::RX_PAR: begin
                                n.rx_pb = rx_in;
                                n.rx_st = spr_pkg::RX_STOP;
                            end
                            default: begin
                                // only the first stop bit is checked
                                n.rx_st = spr_pkg::RX_IDLE; // [R22]
                                if (!(r.mpcm && !rx_ptype)) begin // [R13]
                                    if (n.fcnt != 2'h2) begin
                                        n.fifo[n.fcnt[0]] = rx_ent; // [R5]
                                        n.fcnt = n.fcnt + 2'h1;
                                    end else if (!n.hold_v) begin
                                        n.hold = rx_ent;
                                        n.hold_v = 1'b1;
                                    end
                                end
                            end
                        endcase
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r <= '0;
            r.cb <= spr_pkg::CTRL_B_RST;
            r.cc <= spr_pkg::CTRL_C_RST;
            r.baud <= spr_pkg::BAUD_RST;
            r.tx_line <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign o_rdata = r.rdata;
    assign o_rx_done_irq = r.cb[spr_pkg::B_RXCIE] & i_global_irq_en & rxc; // [R14]
    assign o_tx_done_irq = r.cb[spr_pkg::B_TXCIE] & i_global_irq_en & r.txc; // [R14]
    assign o_tx_empty_irq = r.cb[spr_pkg::B_UDRIE] & i_global_irq_en & ~r.tx_holding_full; // [R14]
    assign link.dev_tx = r.tx_line;
    assign link.dev_tx_oe = r.own; // [R16]
endmodule
`default_nettype wire

/* common/spr_pkg.sv */
// How it works
// R1: one data address: writes transmit, reads receive
// R2: short characters: upper bits ignored, read zero
// R3: data writes dropped while buffer-empty flag clear
// R4: enabled transmitter loads empty shifter, shifts out
// R5: two-entry receive fifo advances on each data read
// R6: receive-done flag follows unread data, flush clears
// R7: tx done on frame end, empty buffer; clearable
// R8: buffer-empty flag shows room, set after reset
// R9: frame error from first stop bit, until read
// R10: overrun: fifo full, char waiting, new start
// R11: parity error when checking enabled, until read
// R12: double speed halves oversampling from 16 to 8
// R13: filter drops non-address frames; transmitter unaffected
// R14: irq needs own enable, global enable, flag
// R15: receiver disable flushes, invalidates
// R16: transmitter disable waits for pending data, releases pin
// R17: software reads ninth rx bit before data
// R18: software writes ninth tx bit before data
// R19: mode field: async, sync, reserved, spi master
// R20: size code: 5 to 8 bits, 111 nine
// R21: parity field: off, reserved, even, odd
// R22: stop select one or two; receiver ignores
// R23: 12-bit divisor; low write reloads prescaler
// R24: data read pops fifo, flags follow next entry
package spr_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 9;
    localparam int BAUD_W = 12;
    localparam logic [2:0] ADDR_DATA = 3'h0;
    localparam logic [2:0] ADDR_STAT_A = 3'h1;
    localparam logic [2:0] ADDR_CTRL_B = 3'h2;
    localparam logic [2:0] ADDR_CTRL_C = 3'h3;
    localparam logic [2:0] ADDR_BAUD_LO = 3'h4;
    localparam logic [2:0] ADDR_BAUD_HI = 3'h5;
    localparam int A_RXC = 7;
    localparam int A_TXC = 6;
    localparam int A_UDRE = 5;
    localparam int A_FE = 4;
    localparam int A_DOR = 3;
    localparam int A_UPE = 2;
    localparam int A_DBL = 1;
    localparam int A_MPCM = 0;
    localparam int B_RXCIE = 7;
    localparam int B_TXCIE = 6;
    localparam int B_UDRIE = 5;
    localparam int B_RXEN = 4;
    localparam int B_TXEN = 3;
    localparam int B_CSZ2 = 2;
    localparam int B_RXB8 = 1;
    localparam int B_TXB8 = 0;
    localparam int C_MODE_HI = 7;
    localparam int C_MODE_LO = 6;
    localparam int C_UPM1 = 5;
    localparam int C_UPM0 = 4;
    localparam int C_USBS = 3;
    localparam int C_CSZ1 = 2;
    localparam int C_CSZ0 = 1;
    localparam logic [7:0] STAT_A_RST = 8'h20;
    localparam logic [7:0] CTRL_B_RST = 8'h00;
    localparam logic [7:0] CTRL_B_WMASK = 8'hFD;
    localparam logic [7:0] CTRL_C_RST = 8'h06;
    localparam logic [11:0] BAUD_RST = 12'h000;
    localparam logic [1:0] MODE_ASYNC = 2'h0;
    localparam logic [1:0] MODE_SYNC = 2'h1;
    localparam logic [1:0] MODE_RSVD = 2'h2;
    localparam logic [1:0] MODE_SPI_MASTER = 2'h3;
    localparam logic [4:0] OS_NORM = 5'h10;
    localparam logic [4:0] OS_DBL = 5'h08;
    localparam int ENT_FE = 9;
    localparam int ENT_PE = 10;
    localparam int ENT_W = 11;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_START = 3'b001,
        TX_DATA = 3'b010,
        TX_PAR = 3'b011,
        TX_STOP1 = 3'b100,
        TX_STOP2 = 3'b101
    } spr_tx_e;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_START = 3'b001,
        RX_DATA = 3'b010,
        RX_PAR = 3'b011,
        RX_STOP = 3'b100
    } spr_rx_e;

    // reserved size codes fall back to eight bits
    function automatic logic [3:0] spr_char_bits(input logic [2:0] code);
        case (code)
            3'h0: spr_char_bits = 4'h5;
            3'h1: spr_char_bits = 4'h6;
            3'h2: spr_char_bits = 4'h7;
            3'h7: spr_char_bits = 4'h9;
            default: spr_char_bits = 4'h8;
        endcase
    endfunction
endpackage

/* common/spr_link_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface spr_link_if;
    logic dev_tx;
    logic dev_tx_oe;
    logic rem_tx;
    logic line_d2r;
    logic line_r2d;
    // released line idles at mark level
    assign line_d2r = dev_tx_oe ? dev_tx : 1'b1;
    assign line_r2d = rem_tx;
    modport dev (output dev_tx, output dev_tx_oe, input line_r2d);
    modport rem (output rem_tx, input line_d2r);
endinterface
`default_nettype wire

/* verilog/spr_baud_gen.sv */
`timescale 1ns/10ps
`default_nettype none
module spr_baud_gen #(
    parameter int BAUD_W = spr_pkg::BAUD_W
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [BAUD_W-1:0] i_divisor,
    input wire logic i_load,
    output logic o_tick
);
    typedef struct packed {
        logic [BAUD_W-1:0] cnt;
        logic tick;
    } spr_baud_s;
    spr_baud_s r, n;

    always_comb begin
        n = r;
        n.tick = 1'b0;
        if (i_load) begin
            n.cnt = i_divisor; // [R23]
        end else if (r.cnt == '0) begin
            n.cnt = i_divisor;
            n.tick = 1'b1;
        end else begin
            n.cnt = r.cnt - 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign o_tick = r.tick;
endmodule
`default_nettype wire

/* verilog/spr_remote.sv */
`timescale 1ns/10ps
`default_nettype none
module spr_remote (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [15:0] i_bit_clks,
    input wire logic [3:0] i_char_bits,
    input wire logic [1:0] i_parity_mode,
    input wire logic i_two_stop,
    input wire logic [8:0] i_tx_data,
    input wire logic i_tx_valid,
    output logic o_tx_ready,
    output logic [8:0] o_rx_data,
    output logic o_rx_valid,
    output logic o_rx_frame_err,
    output logic o_rx_par_err,
    spr_link_if.rem link
);
    typedef struct packed {
        spr_pkg::spr_tx_e tx_st;
        logic [8:0] tx_sh;
        logic [3:0] tx_bit;
        logic [15:0] tx_cnt;
        logic tx_par;
        logic tx_line;
        spr_pkg::spr_rx_e rx_st;
        logic [8:0] rx_sh;
        logic [3:0] rx_bit;
        logic [15:0] rx_cnt;
        logic rx_pb;
        logic [8:0] rx_data;
        logic rx_fe;
        logic rx_pe;
        logic rx_valid;
    } spr_rem_s;
    spr_rem_s r, n;

    logic [15:0] last;
    logic [8:0] mask;
    logic [8:0] rx_word;
    logic rx_in;

    assign last = i_bit_clks - 16'h0001;
    assign mask = ~(9'h1FF << i_char_bits);
    assign rx_in = link.line_d2r;
    assign rx_word = 9'(r.rx_sh >> (4'h9 - i_char_bits)) & mask;

    always_comb begin
        n = r;
        n.rx_valid = 1'b0;
        if (r.tx_st == spr_pkg::TX_IDLE) begin
            if (i_tx_valid) begin
                n.tx_sh = i_tx_data & mask;
                n.tx_par = (^(i_tx_data & mask)) ^ i_parity_mode[0]; // [R21]
                n.tx_st = spr_pkg::TX_START;
                n.tx_cnt = 16'h0000;
                n.tx_bit = 4'h0;
            end
        end else if (r.tx_cnt != last) begin
            n.tx_cnt = r.tx_cnt + 16'h0001;
        end else begin
            n.tx_cnt = 16'h0000;
            case (r.tx_st)
                spr_pkg::TX_START: n.tx_st = spr_pkg::TX_DATA;
                spr_pkg::TX_DATA: begin
                    n.tx_sh = {1'b0, r.tx_sh[8:1]};
                    n.tx_bit = r.tx_bit + 4'h1;
                    if (r.tx_bit == 4'(i_char_bits - 4'h1)) begin
                        n.tx_st = i_parity_mode[1] ? spr_pkg::TX_PAR : spr_pkg::TX_STOP1;
                    end
                end
                spr_pkg::TX_PAR: n.tx_st = spr_pkg::TX_STOP1;
                spr_pkg::TX_STOP1: n.tx_st = i_two_stop ? spr_pkg::TX_STOP2 : spr_pkg::TX_IDLE;
                default: n.tx_st = spr_pkg::TX_IDLE;
            endcase
        end
        case (n.tx_st)
            spr_pkg::TX_START: n.tx_line = 1'b0;
            spr_pkg::TX_DATA: n.tx_line = n.tx_sh[0];
            spr_pkg::TX_PAR: n.tx_line = n.tx_par;
            default: n.tx_line = 1'b1;
        endcase

        n.rx_cnt = r.rx_cnt + 16'h0001;
        case (r.rx_st)
            spr_pkg::RX_IDLE: begin
                n.rx_cnt = 16'h0000;
                if (!rx_in) begin
                    n.rx_st = spr_pkg::RX_START;
                end
            end
            spr_pkg::RX_START: begin
                if (r.rx_cnt == (last >> 1)) begin
                    n.rx_cnt = 16'h0000;
                    n.rx_bit = 4'h0;
                    n.rx_st = rx_in ? spr_pkg::RX_IDLE : spr_pkg::RX_DATA;
                end
            end
            default: begin
                if (r.rx_cnt == last) begin
                    n.rx_cnt = 16'h0000;
                    case (r.rx_st)
                        spr_pkg::RX_DATA: begin
                            n.rx_sh = {rx_in, r.rx_sh[8:1]};
                            n.rx_bit = r.rx_bit + 4'h1;
                            if (r.rx_bit == 4'(i_char_bits - 4'h1)) begin
                                n.rx_st = i_parity_mode[1] ? spr_pkg::RX_PAR : spr_pkg::RX_STOP;
                            end
                        end
                        spr_pkg::RX_PAR: begin
                            n.rx_pb = rx_in;
                            n.rx_st = spr_pkg::RX_STOP;
                        end
                        default: begin
                            n.rx_st = spr_pkg::RX_IDLE;
                            n.rx_data = rx_word;
                            n.rx_fe = ~rx_in;
                            n.rx_pe = i_parity_mode[1] & (r.rx_pb != ((^rx_word) ^ i_parity_mode[0]));
                            n.rx_valid = 1'b1;
                        end
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r <= '0;
            r.tx_line <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign o_tx_ready = r.tx_st == spr_pkg::TX_IDLE;
    assign o_rx_data = r.rx_data;
    assign o_rx_valid = r.rx_valid;
    assign o_rx_frame_err = r.rx_fe;
    assign o_rx_par_err = r.rx_pe;
    assign link.rem_tx = r.tx_line;
endmodule
`default_nettype wire

/* verification/spr_link_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module spr_link_assertions #(
    parameter int DEV_MIN = 15,
    parameter int DEV_MAX = 176,
    parameter int REM_MIN = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic dev_tx,
    input wire logic dev_tx_oe,
    input wire logic rem_tx,
    input wire logic line_d2r,
    input wire logic line_r2d
);
    logic [15:0] d_run_reg;
    logic [15:0] r_run_reg;
    logic d_prev_reg;
    logic r_prev_reg;
    // run counters: cycles each line has held its previous level
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            d_run_reg <= 16'h0000;
            r_run_reg <= 16'h0000;
            d_prev_reg <= 1'b1;
            r_prev_reg <= 1'b1;
        end else begin
            d_prev_reg <= dev_tx;
            r_prev_reg <= rem_tx;
            d_run_reg <= (dev_tx != d_prev_reg) ? 16'h0001 : d_run_reg + 16'h0001;
            r_run_reg <= (rem_tx != r_prev_reg) ? 16'h0001 : r_run_reg + 16'h0001;
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    chk_release_mark: assert property (!dev_tx_oe |-> dev_tx && line_d2r) else $error("released line not high");
    chk_low_owned: assert property (!dev_tx |-> dev_tx_oe) else $error("line low without pin owned");
    chk_take_mark: assert property ($rose(dev_tx_oe) |-> dev_tx) else $error("pin taken at space level");
    chk_drop_mark: assert property ($fell(dev_tx_oe) |-> dev_tx && $past(dev_tx)) else $error("pin dropped mid bit");
    chk_drop_stop: assert property ($fell(dev_tx_oe) |-> d_run_reg >= DEV_MIN) else $error("pin dropped early");
    chk_dev_bit_min: assert property (dev_tx && !d_prev_reg |-> d_run_reg >= DEV_MIN) else $error("short low run");
    chk_dev_low_max: assert property (!dev_tx && !d_prev_reg |-> d_run_reg <= DEV_MAX) else $error("long low run");
    chk_rem_bit_min: assert property (rem_tx && !r_prev_reg |-> r_run_reg >= REM_MIN) else $error("remote short bit");
endmodule
`default_nettype wire

/* verification/serial_port_register_interface_test.sv */
`timescale 1ns/10ps
`default_nettype none
module serial_port_register_interface_test;
    logic clk, rst_n, bus_wr, bus_rd, gie, ack, tx_valid, tx_ready, rx_valid, irq_rx, irq_txd, irq_te;
    logic rx_fe, rx_pe;
    logic [2:0] addr;
    logic [7:0] wdata, rdata;
    logic [8:0] tx_data, rx_data, rx_last;
    logic [3:0] cbits;
    logic [1:0] par;
    int fails, checks, rx_cnt, n;
    spr_link_if spr_link_if_inst();
    spr_device spr_device_inst(.i_ref_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(bus_wr),
        .i_rd(bus_rd), .o_rdata(rdata), .i_global_irq_en(gie), .i_tx_done_irq_ack(ack), .o_rx_done_irq(irq_rx),
        .o_tx_done_irq(irq_txd), .o_tx_empty_irq(irq_te), .link(spr_link_if_inst));
    spr_remote spr_remote_inst(.i_ref_clk(clk), .i_rst_n(rst_n), .i_bit_clks(16'h0010), .i_char_bits(cbits),
        .i_parity_mode(par), .i_two_stop(1'b0), .i_tx_data(tx_data), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready),
        .o_rx_data(rx_data), .o_rx_valid(rx_valid), .o_rx_frame_err(rx_fe), .o_rx_par_err(rx_pe),
        .link(spr_link_if_inst));
    spr_link_assertions spr_link_assertions_inst(.i_ref_clk(clk), .i_rst_n(rst_n), .dev_tx(spr_link_if_inst.dev_tx),
        .dev_tx_oe(spr_link_if_inst.dev_tx_oe), .rem_tx(spr_link_if_inst.rem_tx),
        .line_d2r(spr_link_if_inst.line_d2r), .line_r2d(spr_link_if_inst.line_r2d));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rx_valid === 1'b1) begin
            rx_cnt++;
            rx_last = rx_data;
        end
    end
    task check(input logic [8:0] got, input logic [8:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [2:0] a, input logic [7:0] d, input logic keep = 1'b0);
        addr <= a;
        wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        // back-to-back writes keep the strobe up rather than drop and raise it in one step
        if (!keep) begin
            bus_wr <= 1'b0;
        end
    endtask
    task rd(input logic [2:0] a, input logic [8:0] exp);
        addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        @(posedge clk);
        check({1'b0, rdata}, exp);
    endtask
    // returns once the remote has finished the whole frame
    task send(input logic [8:0] d);
        tx_data <= d;
        tx_valid <= 1'b1;
        do @(posedge clk); while (!tx_ready);
        tx_valid <= 1'b0;
        @(posedge clk);
        for (n = 0; n < 400 && !tx_ready; n++) @(posedge clk);
        check({8'h00, tx_ready}, 9'h001);
    endtask
    task t_reset;
        rd(spr_pkg::ADDR_STAT_A, 9'h020);
        rd(spr_pkg::ADDR_CTRL_B, 9'h000);
        rd(spr_pkg::ADDR_CTRL_C, 9'h006);
        rd(3'h7, 9'h000);
        $display("reset test done");
    endtask
    task t_tx;
        wr(spr_pkg::ADDR_CTRL_B, 8'h18, 1'b1);
        wr(spr_pkg::ADDR_DATA, 8'hA5, 1'b1);
        wr(spr_pkg::ADDR_DATA, 8'h3C);
        for (n = 0; n < 600 && rx_cnt == 0; n++) @(posedge clk);
        check(rx_last, 9'h0A5);
        repeat (400) @(posedge clk);
        check(9'(rx_cnt), 9'h001);
        rd(spr_pkg::ADDR_STAT_A, 9'h060);
        wr(spr_pkg::ADDR_CTRL_B, 8'h78);
        @(posedge clk);
        check({8'h00, irq_txd}, 9'h000);
        gie <= 1'b1;
        @(posedge clk);
        check({7'h00, irq_txd, irq_te}, 9'h003);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        @(posedge clk);
        check({8'h00, irq_txd}, 9'h000);
        wr(spr_pkg::ADDR_CTRL_B, 8'h10);
        repeat (2) @(posedge clk);
        check({8'h00, spr_link_if_inst.dev_tx_oe}, 9'h000);
        $display("transmit test done");
    endtask
    task t_rx;
        wr(spr_pkg::ADDR_CTRL_C, 8'h24);
        cbits <= 4'h7;
        par <= 2'b10;
        send(9'h1FF);
        par <= 2'b11;
        send(9'h055);
        rd(spr_pkg::ADDR_STAT_A, 9'h0A0);
        rd(spr_pkg::ADDR_DATA, 9'h07F);
        rd(spr_pkg::ADDR_STAT_A, 9'h0A4);
        rd(spr_pkg::ADDR_DATA, 9'h055);
        rd(spr_pkg::ADDR_STAT_A, 9'h020);
        par <= 2'b10;
        send(9'h011);
        rd(spr_pkg::ADDR_STAT_A, 9'h0A0);
        wr(spr_pkg::ADDR_CTRL_B, 8'h00);
        // the flush follows the registered enable bit one cycle later
        @(posedge clk);
        rd(spr_pkg::ADDR_STAT_A, 9'h020);
        $display("receive test done");
    endtask
    task t_nine;
        wr(spr_pkg::ADDR_CTRL_C, 8'h36, 1'b1);
        wr(spr_pkg::ADDR_CTRL_B, 8'h9D, 1'b1);
        wr(spr_pkg::ADDR_DATA, 8'h5A);
        cbits <= 4'h9;
        par <= 2'b11;
        for (n = 0; n < 600 && rx_cnt == 1; n++) @(posedge clk);
        check(rx_last, 9'h15A);
        check({7'h00, rx_pe, rx_fe}, 9'h000);
        send(9'h1C3);
        check({8'h00, irq_rx}, 9'h001);
        rd(spr_pkg::ADDR_CTRL_B, 9'h09F);
        rd(spr_pkg::ADDR_DATA, 9'h0C3);
        check({8'h00, irq_rx}, 9'h000);
        $display("nine-bit test done");
    endtask
    task print_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        print_verdict;
    end
    initial begin
        {rst_n, bus_wr, bus_rd, gie, ack, tx_valid, addr, wdata, tx_data, par} = '0;
        cbits = 4'h8;
        rx_last = 9'h000;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset;
        t_tx;
        t_rx;
        t_nine;
        print_verdict;
    end
endmodule
`default_nettype wire
